// ===== common/tsi_pkg.sv
// Shared constants and carrier types for the time slot switching core.
package tsi_pkg;
	// -------------------------------------------------------------------
	// Geometry of streams, channels and the half-clock frame counter
	// -------------------------------------------------------------------
	localparam int          NS          = 16;     // Serial streams each way.
	localparam int          AW          = 9;      // Stream and channel address.
	localparam int          HW          = 10;     // Half-clock counter width.
	localparam int          FAR_W       = 12;     // Alignment result width.
	localparam int          FIFO_DEPTH  = 8;
	localparam logic [1:0]  BOUND_PH    = 2'h0;   // Half clock of bit boundary.
	localparam logic [1:0]  SAMPLE_PH   = 2'h3;   // Three quarters into a bit.
	localparam logic [4:0]  SLOT_START  = 5'h00;
	localparam logic [4:0]  FETCH_PH    = 5'h10;  // Mid slot, one slot ahead.
	localparam logic [4:0]  SLOT_LAST   = 5'h1F;
	localparam logic [4:0]  CHAN_STEP   = 5'h01;
	localparam logic [2:0]  BIT_MSB     = 3'h7;
	localparam logic [4:0]  IDLE_TICKS  = 5'h10;  // Idle run that fixes format.
	localparam logic [1:0]  EVAL_FRAMES = 2'h2;
	localparam logic [8:0]  CM_LAST     = 9'h1FF;
	localparam logic [10:0] CM_LOW_CLR  = 11'h000;
	localparam logic [7:0]  DM_RESET    = 8'h00;
	// Master clock is sampled on the 25 ns system clock.
	localparam int          CLK_NS      = 25;

	// -------------------------------------------------------------------
	// Carrier types
	// -------------------------------------------------------------------
	typedef struct packed {
		logic       loop_back_bit;
		logic       processor_channel_bit;
		logic       const_delay;
		logic       out_en;
		logic       control_bit_output;
		logic [1:0] spare;
		logic [3:0] source_stream_field;
		logic [4:0] source_channel_field;
	} tsi_cm_t;

	typedef struct packed {
		logic [3:0] stream;
		logic [4:0] chan;
		logic [7:0] data;
	} tsi_dmw_t;
endpackage

// ===== core/tsi_core.sv
// Time slot switching core with its data-memory write FIFO.
`timescale 1ns/1ps

// -----------------------------------------------------------------------
// Parameterised FIFO
// -----------------------------------------------------------------------
module tsi_fifo #(
	parameter int W = 17,
	parameter int D = 8
) (
	input  wire logic         clk_i,
	input  wire logic         arst_n_i,
	input  wire logic         in_valid_i,
	output logic              in_ready_o,
	input  wire logic [W-1:0] in_data_i,
	output logic              out_valid_o,
	input  wire logic         out_ready_i,
	output logic      [W-1:0] out_data_o
);
	localparam int PW = $clog2(D);
	logic [W-1:0] mem_r [D];
	logic [PW-1:0] wp_r;
	logic [PW-1:0] rp_r;
	logic [PW:0]   cnt_r;
	wire           push_w = in_valid_i & in_ready_o;
	wire           pop_w  = out_valid_o & out_ready_i;

	// Full and empty come straight from the occupancy count.
	assign in_ready_o  = (cnt_r != (PW+1)'(D));
	assign out_valid_o = (cnt_r != '0);
	assign out_data_o  = mem_r[rp_r];

	// Pointers wrap on the power-of-two depth.
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			wp_r  <= '0;
			rp_r  <= '0;
			cnt_r <= '0;
		end else begin
			if (push_w) begin
				mem_r[wp_r] <= in_data_i;
				wp_r        <= wp_r + PW'(1);
			end
			if (pop_w)
				rp_r <= rp_r + PW'(1);
			cnt_r <= cnt_r + (PW+1)'(push_w) - (PW+1)'(pop_w);
		end
	end
endmodule

// -----------------------------------------------------------------------
// Switching core
// -----------------------------------------------------------------------
module tsi_core (
	input  wire logic                 clk_i,
	input  wire logic                 arst_n_i,
	input  wire logic                 mclk_i,
	input  wire logic                 frame_pulse_in_i,
	input  wire logic                 frame_eval_input_i,
	input  wire logic [tsi_pkg::NS-1:0] rx_i,
	output logic      [tsi_pkg::NS-1:0] tx_o,
	output logic      [tsi_pkg::NS-1:0] tx_oe_n_o,
	output logic                      control_bit_output_o,
	input  wire logic                 output_drive_enable_pin_i,
	input  wire logic                 output_standby_bit_i,
	input  wire logic [tsi_pkg::NS-1:0][3:0] input_offset_i,
	input  wire logic                 start_eval_bit_i,
	output logic                      eval_done_flag_o,
	output logic [tsi_pkg::FAR_W-1:0] frame_alignment_result_o,
	input  wire logic [4:0]           interface_mode_reg_i,
	input  wire logic                 block_program_mode_bit_i,
	input  wire logic                 block_program_go_bit_i,
	output logic                      block_program_busy_o,
	output logic                      block_program_done_o,
	output logic                      gci_format_o,
	input  wire logic                 memory_select_bit_i,
	input  wire logic                 host_wr_i,
	input  wire logic                 host_rd_i,
	input  wire logic [tsi_pkg::AW-1:0] host_addr_i,
	input  wire tsi_pkg::tsi_cm_t     host_wdata_i,
	output logic [15:0]               host_rdata_o
);
	import tsi_pkg::*;

	tsi_cm_t        cm_r [1<<AW];
	logic [7:0]     dm_r [1<<AW];
	logic           mclk_q_r;
	logic           mclk_p_r;
	logic [HW-1:0]  hc_r;
	logic [4:0]     run_r;
	logic           fp_prev_r;
	logic           fe_prev_r;
	logic           start_prev_r;
	logic           go_prev_r;
	logic           armed_r;
	logic [1:0]     frames_r;
	logic [FAR_W-1:0] cap_r;
	logic [AW-1:0]  bp_idx_r;
	logic [NS-1:0]  pend_v_r;
	tsi_dmw_t       pend_r [NS];
	logic [NS-1:0]  grant_w;
	tsi_dmw_t       push_data_w;
	tsi_dmw_t       drain_w;
	logic           fifo_in_ready;
	logic           fifo_out_valid;

	// -------------------------------------------------------------------
	// Master clock edges and frame position
	// -------------------------------------------------------------------
	// Both master clock edges step the half-clock counter; the frame
	// pulse, seen on the boundary edge of the detected format, restarts it.
	wire tick_w    = mclk_q_r ^ mclk_p_r;
	wire rise_w    = mclk_q_r & ~mclk_p_r;
	wire bound_e_w = gci_format_o ? rise_w : ~rise_w;
	wire fp_act_w  = gci_format_o ? frame_pulse_in_i : ~frame_pulse_in_i;
	wire reframe_w = tick_w & bound_e_w & fp_act_w;
	wire [HW-1:0] pos_w = reframe_w ? '0 : hc_r + HW'(1);
	wire [4:0] chan_w   = pos_w[9:5];
	wire [4:0] nchan_w  = chan_w + CHAN_STEP;
	wire       glob_en_w = output_drive_enable_pin_i | output_standby_bit_i;
	wire       bp_start_w = block_program_go_bit_i & ~go_prev_r &
	                        block_program_mode_bit_i;

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			mclk_q_r <= 1'b0;
			mclk_p_r <= 1'b0;
			hc_r     <= '0;
		end else begin
			mclk_q_r <= mclk_i;
			mclk_p_r <= mclk_q_r;
			if (tick_w)
				hc_r <= pos_w;
		end
	end

	// -------------------------------------------------------------------
	// Frame pulse polarity detection
	// -------------------------------------------------------------------
	// The pulse is one master clock wide, so the level that holds for a long run
	// is the idle level: idle low means the rising-framed GCI format.
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			run_r        <= '0;
			fp_prev_r    <= 1'b1;
			gci_format_o <= 1'b0;
		end else if (tick_w) begin
			fp_prev_r <= frame_pulse_in_i;
			if (frame_pulse_in_i != fp_prev_r)
				run_r <= '0;
			else if (run_r != IDLE_TICKS)
				run_r <= run_r + 5'h01;
			else
				gci_format_o <= ~frame_pulse_in_i;
		end
	end

	// -------------------------------------------------------------------
	// Per-stream receive and transmit paths
	// -------------------------------------------------------------------
	for (genvar k = 0; k < NS; k++) begin : g_str
		logic [7:0]    rsh_r;
		logic [7:0]    fetch_r;
		logic [7:0]    out_r;
		logic          fetch_oe_r;
		logic          cur_oe_r;
		wire [HW-1:0]  adj_w  = pos_w - HW'(input_offset_i[k]);
		wire tsi_cm_t  rxe_w  = cm_r[{4'(k), adj_w[9:5]}];
		wire tsi_cm_t  nxe_w  = cm_r[{4'(k), nchan_w}];
		// Loopback takes the bit this stream is driving right now.
		wire           rbit_w = rxe_w.loop_back_bit ? tx_o[k] : rx_i[k];
		wire [7:0]     src_w  = dm_r[{nxe_w.source_stream_field,
		                              nxe_w.source_channel_field}];
		wire [7:0]     fb_w   = nxe_w.processor_channel_bit ?
		                        {nxe_w.source_stream_field[2:0],
		                         nxe_w.source_channel_field} : src_w;
		wire           sstart_w = (pos_w[4:0] == SLOT_START);
		wire [7:0]     cur_w  = sstart_w ? fetch_r : out_r;
		wire [2:0]     bit_w  = BIT_MSB - pos_w[4:2];

		always_ff @(posedge clk_i or negedge arst_n_i) begin
			if (!arst_n_i) begin
				rsh_r        <= '0;
				fetch_r      <= '0;
				out_r        <= '0;
				fetch_oe_r   <= 1'b0;
				cur_oe_r     <= 1'b0;
				tx_o[k]      <= 1'b1;
				tx_oe_n_o[k] <= 1'b1;
				pend_v_r[k]  <= 1'b0;
				pend_r[k]    <= '0;
			end else begin
				// Global drive enable gates every channel's own enable.
				tx_oe_n_o[k] <= ~(glob_en_w & cur_oe_r);
				if (grant_w[k])
					pend_v_r[k] <= 1'b0;
				if (tick_w && adj_w[1:0] == SAMPLE_PH) begin
					rsh_r <= {rsh_r[6:0], rbit_w};
					if (adj_w[4:0] == SLOT_LAST) begin
						// A new byte wins over a same-cycle grant.
						pend_v_r[k] <= 1'b1;
						pend_r[k]   <= '{4'(k), adj_w[9:5],
						                 {rsh_r[6:0], rbit_w}};
					end
				end
				if (tick_w && pos_w[4:0] == FETCH_PH) begin
					fetch_r    <= fb_w;
					fetch_oe_r <= nxe_w.out_en;
				end
				if (tick_w && pos_w[1:0] == BOUND_PH) begin
					tx_o[k] <= cur_w[bit_w];
					if (sstart_w) begin
						out_r    <= fetch_r;
						cur_oe_r <= fetch_oe_r;
					end
				end
			end
		end
	end

	// -------------------------------------------------------------------
	// Data memory write path through the FIFO
	// -------------------------------------------------------------------
	// Lowest stream with a finished byte goes first; sixteen bytes per
	// slot need sixteen of the roughly 156 system clocks in a slot.
	always_comb begin
		grant_w     = '0;
		push_data_w = '0;
		for (int s = NS - 1; s >= 0; s--) begin
			if (pend_v_r[s]) begin
				grant_w     = '0;
				grant_w[s]  = fifo_in_ready;
				push_data_w = pend_r[s];
			end
		end
	end

	// A host read of data memory takes the single port and stalls drain.
	wire drain_rdy_w = ~(host_rd_i & ~memory_select_bit_i);

	tsi_fifo #(
		.W ($bits(tsi_dmw_t)),
		.D (FIFO_DEPTH)
	) u_fifo (
		.clk_i       (clk_i),
		.arst_n_i    (arst_n_i),
		.in_valid_i  (|pend_v_r),
		.in_ready_o  (fifo_in_ready),
		.in_data_i   (push_data_w),
		.out_valid_o (fifo_out_valid),
		.out_ready_i (drain_rdy_w),
		.out_data_o  (drain_w)
	);

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			for (int a = 0; a < (1 << AW); a++)
				dm_r[a] <= DM_RESET;
		end else if (fifo_out_valid && drain_rdy_w) begin
			dm_r[{drain_w.stream, drain_w.chan}] <= drain_w.data;
		end
	end

	// -------------------------------------------------------------------
	// Connection memory, block programming and host access
	// -------------------------------------------------------------------
	// Host writes are ignored while a block fill is running.
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			for (int a = 0; a < (1 << AW); a++)
				cm_r[a] <= '0;
			go_prev_r            <= 1'b0;
			bp_idx_r             <= '0;
			block_program_busy_o <= 1'b0;
			block_program_done_o <= 1'b0;
			host_rdata_o         <= '0;
		end else begin
			go_prev_r            <= block_program_go_bit_i;
			block_program_done_o <= 1'b0;
			if (block_program_busy_o) begin
				cm_r[bp_idx_r] <= {interface_mode_reg_i, CM_LOW_CLR};
				bp_idx_r       <= bp_idx_r + AW'(1);
				if (bp_idx_r == CM_LAST) begin
					block_program_busy_o <= 1'b0;
					block_program_done_o <= 1'b1;
				end
			end else if (bp_start_w) begin
				block_program_busy_o <= 1'b1;
				bp_idx_r             <= '0;
			end else if (host_wr_i && memory_select_bit_i) begin
				cm_r[host_addr_i] <= host_wdata_i;
			end
			if (host_rd_i)
				host_rdata_o <= memory_select_bit_i ? 16'(cm_r[host_addr_i])
				                : {8'h00, dm_r[host_addr_i]};
		end
	end

	// -------------------------------------------------------------------
	// Control bit output and frame alignment evaluation
	// -------------------------------------------------------------------
	// Control bits run one channel ahead, one stream per master clock.
	wire tsi_cm_t cco_e_w = cm_r[{pos_w[4:1], nchan_w}];
	wire fe_edge_w = gci_format_o ? (frame_eval_input_i & ~fe_prev_r)
	                 : (~frame_eval_input_i & fe_prev_r);

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			control_bit_output_o     <= 1'b0;
			fe_prev_r                <= 1'b1;
			start_prev_r             <= 1'b0;
			armed_r                  <= 1'b0;
			frames_r                 <= '0;
			cap_r                    <= '0;
			eval_done_flag_o         <= 1'b0;
			frame_alignment_result_o <= '0;
		end else begin
			start_prev_r <= start_eval_bit_i;
			if (tick_w) begin
				fe_prev_r <= frame_eval_input_i;
				if (pos_w[0] == 1'b0)
					control_bit_output_o <= cco_e_w.control_bit_output;
				if (armed_r && fe_edge_w)
					cap_r <= FAR_W'(pos_w);
			end
			if (start_eval_bit_i && !start_prev_r) begin
				armed_r          <= 1'b1;
				frames_r         <= '0;
				eval_done_flag_o <= 1'b0;
			end else if (armed_r && reframe_w) begin
				frames_r <= frames_r + 2'h1;
				if (frames_r + 2'h1 == EVAL_FRAMES) begin
					armed_r                  <= 1'b0;
					eval_done_flag_o         <= 1'b1;
					frame_alignment_result_o <= cap_r;
				end
			end
		end
	end
endmodule

// ===== testbench/tsi_core_asserts.sv
// Concurrent checks on the switching core's control outputs.
`timescale 1ns/1ps
module tsi_core_chk
	import tsi_pkg::*;
(
	input wire logic                   clk_i,
	input wire logic                   arst_n_i,
	input wire logic                   output_drive_enable_pin_i,
	input wire logic                   output_standby_bit_i,
	input wire logic [tsi_pkg::NS-1:0] tx_oe_n_o,
	input wire logic                   block_program_go_bit_i,
	input wire logic                   block_program_mode_bit_i,
	input wire logic                   block_program_busy_o,
	input wire logic                   block_program_done_o,
	input wire logic                   start_eval_bit_i,
	input wire logic                   eval_done_flag_o,
	input wire logic [tsi_pkg::FAR_W-1:0] frame_alignment_result_o,
	input wire logic                   host_rd_i,
	input wire logic [15:0]            host_rdata_o
);
	localparam int EV_LO = 4900;
	localparam int EV_HI = 10100;
	logic [14:0] ev_cnt_r;
	logic [9:0]  bp_cnt_r;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!arst_n_i);

	// Cycles since the last start rise; saturates well past two frames.
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i)
			ev_cnt_r <= 15'h0000;
		else if ($rose(start_eval_bit_i))
			ev_cnt_r <= 15'h0000;
		else if (ev_cnt_r != 15'h7FFF)
			ev_cnt_r <= ev_cnt_r + 15'h0001;
	end

	// Cycles of the running fill; a long plain delay would slow the tools.
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i)
			bp_cnt_r <= 10'h000;
		else if (!block_program_busy_o)
			bp_cnt_r <= 10'h000;
		else
			bp_cnt_r <= bp_cnt_r + 10'h001;
	end

	chk_float_all: assert property (
		(!output_drive_enable_pin_i && !output_standby_bit_i)[*3]
		|=> &tx_oe_n_o) else $error("outputs driven in standby");
	chk_fill_start: assert property (
		$rose(block_program_go_bit_i) && block_program_mode_bit_i &&
		!block_program_busy_o |=> block_program_busy_o)
		else $error("fill did not start");
	chk_fill_length: assert property (
		$rose(block_program_done_o) |-> bp_cnt_r == 10'h200 &&
		!block_program_busy_o)
		else $error("fill length wrong");
	chk_done_pulse: assert property (
		block_program_done_o |=> !block_program_done_o)
		else $error("fill done longer than a cycle");
	chk_done_cause: assert property (
		$rose(block_program_done_o) |-> $past(block_program_busy_o))
		else $error("fill done without fill");
	chk_flag_holds: assert property (
		eval_done_flag_o && !start_eval_bit_i |=> eval_done_flag_o)
		else $error("done flag dropped");
	chk_result_holds: assert property (
		eval_done_flag_o && $past(eval_done_flag_o)
		|-> $stable(frame_alignment_result_o))
		else $error("result moved while done");
	chk_rdata_idle: assert property (
		!$past(host_rd_i) |-> $stable(host_rdata_o))
		else $error("read data moved without read");
	chk_eval_time: assert property (
		$rose(eval_done_flag_o) |-> ev_cnt_r >= EV_LO && ev_cnt_r <= EV_HI)
		else $error("evaluation not two frames");

	cov_fill: cover property ($rose(block_program_done_o));
	cov_eval: cover property ($rose(eval_done_flag_o));
	cov_float: cover property (&tx_oe_n_o && !output_drive_enable_pin_i);
endmodule

bind tsi_core tsi_core_chk u_chk (.clk_i, .arst_n_i,
	.output_drive_enable_pin_i, .output_standby_bit_i, .tx_oe_n_o,
	.block_program_go_bit_i, .block_program_mode_bit_i,
	.block_program_busy_o, .block_program_done_o, .start_eval_bit_i,
	.eval_done_flag_o, .frame_alignment_result_o, .host_rd_i,
	.host_rdata_o);

// ===== testbench/tsi_far_model.sv
// Behavioural backplane: master clock, frame pulse, sources and sink.
`timescale 1ns/1ps
module tsi_far_model
	import tsi_pkg::*;
#(
	parameter int FE_POS = 40
) (
	output logic                   mclk_o,
	output logic                   frame_pulse_o,
	output logic                   frame_eval_o,
	output logic [tsi_pkg::NS-1:0] rx_o,
	input  wire logic [tsi_pkg::NS-1:0] tx_i,
	input  wire logic [tsi_pkg::NS-1:0] tx_oe_n_i,
	input  wire logic [tsi_pkg::NS-1:0][3:0] offset_i
);
	logic [9:0] hc;
	logic [9:0] a;
	logic [7:0] b;
	logic [7:0] sh    [NS];
	logic [7:0] out_q [NS][32];
	logic       hz_q  [NS][32];

	// Byte sent on each stream and channel, every frame.
	function automatic logic [7:0] src_byte(input int s, input int c);
		return {s[3:0], c[3:0]} ^ 8'h5A;
	endfunction

	// Even half counts are falling edges; count 0 is the frame boundary.
	// Sources lag by their offset so the core must apply it to recover.
	initial begin
		mclk_o = 1'b0;
		hc = 10'h3FE;
		forever begin
			frame_pulse_o = !(hc == 10'h3FF || hc == 10'h000);
			frame_eval_o = !(hc >= 10'(FE_POS) && hc < 10'(FE_POS + 16));
			for (int s = 0; s < NS; s++) begin
				a = hc - 10'(offset_i[s]);
				b = src_byte(s, int'(a[9:5]));
				rx_o[s] = b[3'h7 - a[4:2]];
			end
			#122.070;
			mclk_o = ~mclk_o;
			hc = hc + 10'h001;
			// Sink samples each output three quarters into the bit cell.
			if (hc[1:0] == 2'h3) begin
				for (int s = 0; s < NS; s++) begin
					sh[s] = {sh[s][6:0], tx_i[s]};
					if (hc[4:2] == 3'h7) begin
						out_q[s][hc[9:5]] = sh[s];
						hz_q[s][hc[9:5]] = tx_oe_n_i[s];
					end
				end
			end
		end
	end
endmodule

// ===== testbench/tsi_core_bench.sv
// Self-checking bench for the time slot switching core.
`timescale 1ns/1ps
module tsi_core_bench;
	import tsi_pkg::*;
	localparam int FE_POS = 40;
	localparam int FRAME  = 5000;
	logic                     clk_i, arst_n_i, output_drive_enable_pin, output_standby_bit, start, go, bpm;
	logic                     ms, wr, rd, mclk, fp, fe, control_bit_output, ed, bb, bd, gci;
	logic [NS-1:0]            rx, tx, oe_n;
	logic [NS-1:0][3:0]       offs;
	logic [4:0]               pat;
	logic [AW-1:0]            addr;
	tsi_cm_t                  wdata;
	logic [FAR_W-1:0]         far;
	logic [15:0]              rdata, got;
	int                       n, fails, check_count;

	tsi_core u_dut (.clk_i, .arst_n_i, .mclk_i(mclk),
		.frame_pulse_in_i(fp), .frame_eval_input_i(fe), .rx_i(rx),
		.tx_o(tx), .tx_oe_n_o(oe_n), .control_bit_output_o(control_bit_output),
		.output_drive_enable_pin_i(output_drive_enable_pin), .output_standby_bit_i(output_standby_bit),
		.input_offset_i(offs), .start_eval_bit_i(start),
		.eval_done_flag_o(ed), .frame_alignment_result_o(far),
		.interface_mode_reg_i(pat), .block_program_mode_bit_i(bpm),
		.block_program_go_bit_i(go), .block_program_busy_o(bb),
		.block_program_done_o(bd), .gci_format_o(gci),
		.memory_select_bit_i(ms), .host_wr_i(wr), .host_rd_i(rd),
		.host_addr_i(addr), .host_wdata_i(wdata), .host_rdata_o(rdata));
	tsi_far_model #(.FE_POS(FE_POS)) u_far (.mclk_o(mclk),
		.frame_pulse_o(fp), .frame_eval_o(fe), .rx_o(rx), .tx_i(tx),
		.tx_oe_n_i(oe_n), .offset_i(offs));

	// Compare one value and count it.
	task automatic check(input string nm, input logic [15:0] seen, exp);
		check_count++;
		if (seen !== exp) begin
			fails++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic final_report();
		$display("checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// A wait that ran out of cycles ends the run as a failure.
	task automatic bound(input int lim);
		if (n >= lim) begin
			check("wait", 16'h0000, 16'h0001);
			final_report();
		end
	endtask

	// Host strobes last one cycle; read data is taken after it settles.
	task automatic host_wr(input logic s, input logic [8:0] a,
		input logic [15:0] d);
		@(posedge clk_i);
		ms <= s;
		addr <= a;
		wdata <= tsi_cm_t'(d);
		wr <= 1'b1;
		@(posedge clk_i);
		wr <= 1'b0;
	endtask

	task automatic host_rd(input logic s, input logic [8:0] a);
		@(posedge clk_i);
		ms <= s;
		addr <= a;
		rd <= 1'b1;
		@(posedge clk_i);
		rd <= 1'b0;
		@(posedge clk_i);
		#1 got = rdata;
	endtask

	initial begin
		clk_i = 1'b0;
		forever #12.5 clk_i = ~clk_i;
	end

	// Main sequence: fill, switching paths, drivers, loopback, evaluation.
	initial begin
		{arst_n_i, output_drive_enable_pin, output_standby_bit, start, go, bpm, ms, wr, rd} = '0;
		{pat, addr, wdata, offs, fails, check_count} = '0;
		repeat (6) @(posedge clk_i);
		arst_n_i <= 1'b1;
		check("oe_n", oe_n, 16'hFFFF);
		@(posedge clk_i);
		pat <= 5'h02; // Fill pattern drives every channel.
		bpm <= 1'b1;
		go <= 1'b1;
		for (n = 0; n < 8 && bb !== 1'b1; n++) @(posedge clk_i);
		bound(8);
		go <= 1'b0;
		@(posedge clk_i);
		go <= 1'b1;
		for (n = 0; n < 600 && bd !== 1'b1; n++) @(posedge clk_i);
		bound(600);
		repeat (2) @(posedge clk_i);
		check("busy", 16'(bb), 16'h0000);
		go <= 1'b0;
		bpm <= 1'b0;
		host_rd(1'b1, 9'h000);
		check("cm0", got, 16'h1000);
		host_rd(1'b1, 9'h1FF);
		check("cm511", got, 16'h1000);
		$display("test fill done");
		host_wr(1'b1, 9'h003, 16'h50A5);
		host_wr(1'b1, 9'h005, 16'h1047);
		host_wr(1'b1, 9'h025, 16'h1047);
		host_wr(1'b1, 9'h006, 16'h0800); // Floated, control bit set.
		host_wr(1'b0, 9'h047, 16'h00FF);
		offs[4] <= 4'h9;
		output_drive_enable_pin <= 1'b1;
		repeat (3 * FRAME) @(posedge clk_i);
		host_rd(1'b1, 9'h003);
		check("cm3", got, 16'h50A5);
		host_rd(1'b0, 9'h047);
		check("dm2_7", got, {8'h00, u_far.src_byte(2, 7)});
		host_rd(1'b0, 9'h08A);
		check("dm4_10", got, {8'h00, u_far.src_byte(4, 10)});
		check("tx0_3", {8'h00, u_far.out_q[0][3]}, 16'h00A5);
		check("tx0_5", {8'h00, u_far.out_q[0][5]},
			{8'h00, u_far.src_byte(2, 7)});
		check("tx1_5", {8'h00, u_far.out_q[1][5]},
			{8'h00, u_far.src_byte(2, 7)});
		check("tx0_10", {8'h00, u_far.out_q[0][10]},
			{8'h00, u_far.src_byte(0, 0)});
		check("hz0_6", 16'(u_far.hz_q[0][6]), 16'h0001);
		check("hz0_5", 16'(u_far.hz_q[0][5]), 16'h0000);
		check("gci", 16'(gci), 16'h0000);
		// Control bit of stream 0 runs one channel ahead of its slot.
		for (n = 0; n < 2 * FRAME && u_far.hc != 10'h0A1; n++)
			@(posedge clk_i);
		bound(2 * FRAME);
		check("cco0_6", 16'(control_bit_output), 16'h0001);
		for (n = 0; n < 2 * FRAME && u_far.hc != 10'h0C1; n++)
			@(posedge clk_i);
		bound(2 * FRAME);
		check("cco0_7", 16'(control_bit_output), 16'h0000);
		$display("test switching done");
		output_drive_enable_pin <= 1'b0;
		repeat (FRAME) @(posedge clk_i);
		check("oe_off", oe_n, 16'hFFFF);
		check("hz_off", 16'(u_far.hz_q[0][5]), 16'h0001);
		output_standby_bit <= 1'b1;
		repeat (FRAME) @(posedge clk_i);
		check("hz_sb", 16'(u_far.hz_q[0][5]), 16'h0000);
		$display("test drivers done");
		offs[4] <= 4'h0; // Stream 4 offset back to zero; the loopback on stream 3 keeps its own offset at zero.
		host_wr(1'b1, 9'h069, 16'hD03C);
		repeat (2 * FRAME) @(posedge clk_i);
		host_rd(1'b0, 9'h069);
		check("loop", got, 16'h003C);
		$display("test loopback done");
		start <= 1'b1; // Start has been low far longer than a frame.
		for (n = 0; n < 3 * FRAME && ed !== 1'b1; n++) @(posedge clk_i);
		bound(3 * FRAME);
		check("far", 16'(far >= FE_POS - 1 && far <= FE_POS + 1),
			16'h0001);
		start <= 1'b0;
		$display("test evaluation done");
		final_report();
	end
endmodule
